// ===== hw/prot_consts.svh
// Purpose: Offsets, field positions and timing counts of the protection decision block
// Assumes: APB byte addresses on a 12-bit word-aligned map
// Notes: Definitions only
`ifndef PROT_CONSTS_SVH
`define PROT_CONSTS_SVH

// Clock and time base
`define CLK_PERIOD_NS 25
`define MS_NS 1000000
`define MS_CYCLES_DFLT (`MS_NS / `CLK_PERIOD_NS)
`define VB_PERIOD_MS 20
`define MS_PER_S 1000
`define HOLD_MAX_S 60

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_HOLD 12'h004
`define OFS_VS 12'h008
`define OFS_TEST_IN 12'h00C
`define OFS_TEST_RESP 12'h010
`define OFS_LIVE 12'h014
`define OFS_RELAY 12'h018
`define OFS_TSET 12'h040
`define OFS_ISEL 12'h100
`define OFS_OSEL 12'h180

// Control field positions
`define CTRL_HOLD_LSB 0
`define CTRL_INTEG_LSB 3
`define CTRL_TEST_BIT 8

// Timer indexes
`define T_UV 0
`define T_OVLO 1
`define T_OVHI 2
`define T_UF1 3
`define T_UF2 4
`define T_OF 5
`define T_OC 6
`define T_SEF 7
`define T_ND 8
`define T_LFP 9
`define T_RP 10
`define T_FF 11
`define T_DO_BASE 12

// Counts of timers, settings, lines and relays
`define N_TMR 12
`define N_TSET 15
`define N_LINE 32
`define N_RELAY 15

`endif

// ===== hw/prot_pkg.sv
// Purpose: Types shared by the protection decision block
// Assumes: prot_consts.svh gives the sizes
// Notes: Whole module state is one packed struct
`include "prot_consts.svh"
package prot_pkg;

   // Pickup flags from the measuring elements
   typedef struct packed {
      logic [2:0] uv_ph;    // Per-phase under voltage
      logic [2:0] ovlo_ph;  // Per-phase over voltage low stage
      logic [2:0] ovhi_ph;  // Per-phase over voltage high stage
      logic uf1;
      logic uf2;
      logic of;
      logic oc;
      logic sef;
      logic nd;
      logic lfp;
      logic rp;
      logic ff;
      logic [5:0] other;    // Instantaneous functions passed straight to the array
   } elem_in_s;

   // Timer behaviours
   typedef enum logic [1:0] {
      TM_PLAIN = 2'b00,
      TM_HOLD = 2'b01,
      TM_INTEG = 2'b10
   } tmode_e;

   // All state of the block
   typedef struct packed {
      logic [15:0] ms_cnt;
      logic ms_tick;
      logic [4:0] vb_ms;
      logic [`N_TMR-1:0][15:0] tcnt;
      logic [`N_TMR-1:0][15:0] gcnt;
      logic [`N_TSET-1:0][15:0] tset;
      logic [2:0] hold_en;
      logic [2:0] integ_en;
      logic test_mode;
      logic [5:0] hold_s;
      logic [15:0] vs;
      logic [31:0] test_in;
      logic vb_prev_p;
      logic vb_prev_c;
      logic vb_p;
      logic vb_c;
      logic [`N_LINE-1:0][31:0] isel;
      logic [`N_LINE-1:0][`N_RELAY-1:0] osel;
      logic [`N_RELAY-1:0] relay;
      logic [`N_RELAY-1:0] test_resp;
      logic [31:0] live;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_s;

endpackage

// ===== hw/prot_matrix.sv
// Purpose: Protection timing, voltage balance and AND-OR trip matrix behind an APB slave
// Assumes: Element pickup flags and logic inputs are synchronous to pclk
// Notes: Timers count in milliseconds from an internal tick
//
// Contract
// [RULE1] Voltage timers start only on all phases
// [RULE2] Inhibit input holds under voltage timer
// [RULE3] Two over voltage stages ORed together
// [RULE4] Two under, one over frequency timer
// [RULE5] Inhibit holds under frequency timers only
// [RULE6] Balance every 20ms, confirm twice running
// [RULE7] Positive excess flags comparison fuse failure
// [RULE8] Negative excess flags protection fuse failure
// [RULE9] Balance gives three array outputs
// [RULE10] Three timers offer a hold mode
// [RULE11] Hold keeps count until reset time
// [RULE12] Hold reset time zero to sixty seconds
// [RULE13] Power and field timers integrate
// [RULE14] Integrating trips across short gaps
// [RULE15] Operated integrating timer clears on dropout
// [RULE16] Array has thirty-two input signals
// [RULE17] Line ANDs all selected inputs
// [RULE18] Each relay ORs connected lines
// [RULE19] Thirty-two independent logic lines
// [RULE20] 32-bit input, 15-bit output select words
// [RULE21] Scheme test leaves live relays alone
// [RULE22] Inhibit forces those timers to reset
// [RULE23] Only logic inputs six-nine inverted; the array inverts logic_in[3:0] instead
// [RULE24] Empty selection line drives nothing
// [RULE25] Plain timer clears on pickup loss
//
// Our own choices: the address map and the APB register port.
`include "prot_consts.svh"
module prot_matrix
   import prot_pkg::*;
#(
   parameter int MS_CYCLES = `MS_CYCLES_DFLT
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measuring elements and logic inputs
   input wire elem_in_s elem,
   input wire logic [15:0] vab_diff,
   input wire logic [15:0] vbc_diff,
   input wire logic [7:0] logic_in,
   input wire logic uf_uv_inhibit,
   // Relay drives
   output logic [`N_RELAY-1:0] relay_out
);

   state_s s_q;  // Registered state
   state_s s_d;  // Next state

   logic [`N_TMR-1:0] pick;  // Pickup per timer
   logic [`N_TMR-1:0] inh;   // Timers forced to reset
   logic [`N_TMR-1:0] tout;  // Timer outputs
   logic [31:0] live_vec;    // Array inputs from live protection

   // Counter step that stops at full scale
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   // Behaviour of each timer from its index and the control bits
   function automatic tmode_e tmr_mode(input int i, input logic [2:0] hen,
                                       input logic [2:0] ien);
      tmr_mode = TM_PLAIN;
      if (i >= `T_OC && i <= `T_ND && hen[i-`T_OC]) begin
         tmr_mode = TM_HOLD;  // [RULE10]
      end
      if (i >= `T_LFP && i <= `T_FF && ien[i-`T_LFP]) begin
         tmr_mode = TM_INTEG;  // [RULE13]
      end
   endfunction

   // AND-OR array: used for both live and trial vectors
   function automatic logic [`N_RELAY-1:0] scheme_eval(
      input logic [31:0] v,
      input logic [`N_LINE-1:0][31:0] is,
      input logic [`N_LINE-1:0][`N_RELAY-1:0] os);
      logic and_t;
      scheme_eval = '0;
      for (int l = 0; l < `N_LINE; l++) begin  // [RULE19]
         // An empty word would pass trivially, so it is blocked here
         and_t = (is[l] != 32'h0000_0000) && ((v & is[l]) == is[l]);  // [RULE17] [RULE24]
         if (and_t) begin
            scheme_eval = scheme_eval | os[l];  // [RULE18] [RULE20]
         end
      end
   endfunction

   // Decode of mapped addresses, shared by read and error path
   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a <= `OFS_RELAY) ||
                (a >= `OFS_TSET && a < `OFS_TSET + 12'(4 * `N_TSET)) ||
                (a >= `OFS_ISEL && a < `OFS_OSEL + 12'(4 * `N_LINE));
   endfunction

   // Three-phase functions need every phase element at once
   assign pick[`T_UV] = &elem.uv_ph;    // [RULE1]
   assign pick[`T_OVLO] = &elem.ovlo_ph;  // [RULE1] [RULE3]
   assign pick[`T_OVHI] = &elem.ovhi_ph;  // [RULE1] [RULE3]
   assign pick[`T_UF1] = elem.uf1;       // [RULE4]
   assign pick[`T_UF2] = elem.uf2;       // [RULE4]
   assign pick[`T_OF] = elem.of;         // [RULE4]
   assign pick[`T_OC] = elem.oc;
   assign pick[`T_SEF] = elem.sef;
   assign pick[`T_ND] = elem.nd;
   assign pick[`T_LFP] = elem.lfp;
   assign pick[`T_RP] = elem.rp;
   assign pick[`T_FF] = elem.ff;

   // Inhibit reaches under voltage and both under frequency timers, not over frequency
   always_comb begin
      inh = '0;
      inh[`T_UV] = uf_uv_inhibit;   // [RULE2] [RULE22]
      inh[`T_UF1] = uf_uv_inhibit;  // [RULE5] [RULE22]
      inh[`T_UF2] = uf_uv_inhibit;  // [RULE5] [RULE22]
   end

   // Outputs assert once the count reaches its setting while picked up
   generate
      for (genvar g = 0; g < `N_TMR; g++) begin : g_tout
         assign tout[g] = pick[g] && (s_q.tcnt[g] >= s_q.tset[g]);  // [RULE25]
      end
   endgenerate

   // Array input order: 19 protection, 8 logic inputs, 4 inverted inputs, 1 blocking
   assign live_vec = {~s_q.vb_p,                  // [RULE9]
                      ~logic_in[3:0],             // [RULE23]
                      logic_in,
                      elem.other,
                      tout[`T_FF], tout[`T_RP], tout[`T_LFP],
                      tout[`T_ND], tout[`T_SEF], tout[`T_OC],
                      s_q.vb_c, s_q.vb_p,         // [RULE9]
                      tout[`T_OF], tout[`T_UF2], tout[`T_UF1],
                      tout[`T_OVLO] | tout[`T_OVHI],  // [RULE3]
                      tout[`T_UV]};               // [RULE16]

   // Next-state logic for the whole block
   always_comb begin
      logic [15:0] lim;
      logic [15:0] dset;
      logic [16:0] ab;
      logic [16:0] bc;
      logic [16:0] pos;
      logic [16:0] neg;
      logic now_p;
      logic now_c;
      logic wr;
      int idx;
      tmode_e m;
      s_d = s_q;
      lim = 16'({10'h000, s_q.hold_s} * 16'd`MS_PER_S);  // [RULE12]
      dset = '0;
      // Sign extension keeps a negative difference negative in the compare
      ab = {vab_diff[15], vab_diff};
      bc = {vbc_diff[15], vbc_diff};
      pos = {1'b0, s_q.vs};
      neg = 17'h0_0000 - pos;
      now_p = 1'b0;
      now_c = 1'b0;
      wr = 1'b0;
      idx = 0;
      m = TM_PLAIN;

      // Millisecond tick
      // One tick serves every timer, so a start may land up to one tick late
      s_d.ms_tick = 1'b0;
      if (s_q.ms_cnt >= 16'(MS_CYCLES - 1)) begin
         s_d.ms_cnt = '0;
         s_d.ms_tick = 1'b1;
      end else begin
         s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
      end

      // Element timers
      for (int i = 0; i < `N_TMR; i++) begin
         m = tmr_mode(i, s_q.hold_en, s_q.integ_en);
         if (i >= `T_LFP) begin
            dset = s_q.tset[`T_DO_BASE + i - `T_LFP];
         end else begin
            dset = '0;
         end
         if (inh[i]) begin
            // Held in reset for as long as the inhibit is energised
            s_d.tcnt[i] = '0;  // [RULE2] [RULE5] [RULE22]
            s_d.gcnt[i] = '0;
         end else if (m == TM_PLAIN) begin
            s_d.gcnt[i] = '0;
            if (!pick[i]) begin
               s_d.tcnt[i] = '0;  // [RULE25]
            end else if (s_q.ms_tick) begin
               s_d.tcnt[i] = sat_inc(s_q.tcnt[i]);  // [RULE4]
            end
         end else if (m == TM_INTEG && !pick[i] && s_q.tcnt[i] >= s_q.tset[i]) begin
            // Operated: the trip must not linger after the element resets
            s_d.tcnt[i] = '0;  // [RULE15]
            s_d.gcnt[i] = '0;
         end else if (s_q.ms_tick) begin
            if (pick[i]) begin
               // Continue from the kept value
               s_d.tcnt[i] = sat_inc(s_q.tcnt[i]);  // [RULE11] [RULE14]
               s_d.gcnt[i] = '0;
            end else if (s_q.tcnt[i] != 16'h0000) begin
               // Gap counted in ticks; a zero hold setting resets at the first one
               if (m == TM_HOLD && (lim == 16'h0000 || s_q.gcnt[i] >= lim - 16'h0001)) begin
                  s_d.tcnt[i] = '0;  // [RULE11]
                  s_d.gcnt[i] = '0;
               end else if (m == TM_INTEG && s_q.gcnt[i] >= dset) begin
                  s_d.tcnt[i] = '0;  // [RULE14]
                  s_d.gcnt[i] = '0;
               end else begin
                  s_d.gcnt[i] = sat_inc(s_q.gcnt[i]);
               end
            end
         end
      end

      // Voltage balance every 20 ms, confirmed on two evaluations in a row
      if (s_q.ms_tick) begin
         if (s_q.vb_ms == 5'(`VB_PERIOD_MS - 1)) begin
            s_d.vb_ms = '0;
            now_c = ($signed(ab) > $signed(pos)) || ($signed(bc) > $signed(pos));  // [RULE7]
            now_p = ($signed(ab) < $signed(neg)) || ($signed(bc) < $signed(neg));  // [RULE8]
            s_d.vb_prev_c = now_c;
            s_d.vb_prev_p = now_p;
            s_d.vb_c = s_q.vb_prev_c & now_c;  // [RULE6]
            s_d.vb_p = s_q.vb_prev_p & now_p;  // [RULE6]
         end else begin
            s_d.vb_ms = s_q.vb_ms + 5'h01;
         end
      end

      // Live array drives the relays; trial vector only feeds a status word
      s_d.live = live_vec;
      s_d.relay = scheme_eval(live_vec, s_q.isel, s_q.osel);  // [RULE18]
      if (s_q.test_mode) begin
         s_d.test_resp = scheme_eval(s_q.test_in, s_q.isel, s_q.osel);  // [RULE21]
      end else begin
         s_d.test_resp = '0;
      end

      // APB: setup cycle prepares the answer, access cycle completes it
      // Zero wait state: pready follows every setup by exactly one cycle
      if (psel && !penable) begin
         s_d.pready = 1'b1;
         s_d.pslverr = !addr_ok(paddr);
         s_d.prdata = '0;
         if (!pwrite) begin
            if (paddr == `OFS_CTRL) begin
               s_d.prdata[`CTRL_HOLD_LSB +: 3] = s_q.hold_en;
               s_d.prdata[`CTRL_INTEG_LSB +: 3] = s_q.integ_en;
               s_d.prdata[`CTRL_TEST_BIT] = s_q.test_mode;
            end else if (paddr == `OFS_HOLD) begin
               s_d.prdata[5:0] = s_q.hold_s;
            end else if (paddr == `OFS_VS) begin
               s_d.prdata[15:0] = s_q.vs;
            end else if (paddr == `OFS_TEST_IN) begin
               s_d.prdata = s_q.test_in;
            end else if (paddr == `OFS_TEST_RESP) begin
               s_d.prdata[`N_RELAY-1:0] = s_q.test_resp;
            end else if (paddr == `OFS_LIVE) begin
               s_d.prdata = s_q.live;
            end else if (paddr == `OFS_RELAY) begin
               s_d.prdata[`N_RELAY-1:0] = s_q.relay;
            end else if (paddr >= `OFS_TSET && paddr < `OFS_TSET + 12'(4 * `N_TSET)) begin
               idx = int'(paddr[7:2]) - int'(`OFS_TSET >> 2);
               s_d.prdata[15:0] = s_q.tset[idx];
            end else if (paddr >= `OFS_ISEL && paddr < `OFS_OSEL) begin
               s_d.prdata = s_q.isel[paddr[6:2]];
            end else if (addr_ok(paddr)) begin
               s_d.prdata[`N_RELAY-1:0] = s_q.osel[paddr[6:2]];
            end
         end
      end else begin
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
      end

      // Writes land at the completing edge; unmapped or read-only words are ignored
      // A refused address never reaches the settings, so a stray write is harmless
      wr = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
      if (wr) begin
         if (paddr == `OFS_CTRL) begin
            s_d.hold_en = pwdata[`CTRL_HOLD_LSB +: 3];
            s_d.integ_en = pwdata[`CTRL_INTEG_LSB +: 3];
            s_d.test_mode = pwdata[`CTRL_TEST_BIT];
         end else if (paddr == `OFS_HOLD) begin
            // Anything past the top setting is held at sixty seconds
            s_d.hold_s = (pwdata[31:0] > 32'(`HOLD_MAX_S)) ? 6'(`HOLD_MAX_S) : pwdata[5:0];  // [RULE12]
         end else if (paddr == `OFS_VS) begin
            s_d.vs = pwdata[15:0];
         end else if (paddr == `OFS_TEST_IN) begin
            s_d.test_in = pwdata;
         end else if (paddr >= `OFS_TSET && paddr < `OFS_TSET + 12'(4 * `N_TSET)) begin
            idx = int'(paddr[7:2]) - int'(`OFS_TSET >> 2);
            s_d.tset[idx] = pwdata[15:0];
         end else if (paddr >= `OFS_ISEL && paddr < `OFS_OSEL) begin
            s_d.isel[paddr[6:2]] = pwdata;  // [RULE20]
         end else if (paddr >= `OFS_OSEL) begin
            s_d.osel[paddr[6:2]] = pwdata[`N_RELAY-1:0];  // [RULE20]
         end
      end
   end

   // State register; all control state starts cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign relay_out = s_q.relay;

   // A voltage timer advances only when all phases were picked up
   chk_uv_all_phase: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE1]
      (s_q.tcnt[`T_UV] > $past(s_q.tcnt[`T_UV])) |-> $past(&elem.uv_ph))
      else $error("under voltage timer advanced without all phases");

   // Under voltage timer stays at zero under inhibit
   chk_uv_inhibit_hold: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE2]
      uf_uv_inhibit |=> s_q.tcnt[`T_UV] == 16'h0000)
      else $error("under voltage timer ran while inhibited");

   // Both under frequency timers stay at zero under inhibit
   chk_uf_inhibit_hold: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE5] [RULE22]
      uf_uv_inhibit |=> (s_q.tcnt[`T_UF1] == 16'h0000) && (s_q.tcnt[`T_UF2] == 16'h0000))
      else $error("under frequency timer ran while inhibited");

   // Protection fuse failure only rises after a failing previous evaluation
   chk_vb_two_evals: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE6] [RULE8]
      $rose(s_q.vb_p) |-> $past(s_q.vb_prev_p) && $past(s_q.ms_tick))
      else $error("fuse failure confirmed on a single evaluation");

   // Operated integrating timer clears one cycle after dropout
   chk_integ_clear_now: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE15]
      (tmr_mode(`T_LFP, s_q.hold_en, s_q.integ_en) == TM_INTEG && !pick[`T_LFP] &&
       s_q.tcnt[`T_LFP] >= s_q.tset[`T_LFP])
      |=> s_q.tcnt[`T_LFP] == 16'h0000 && s_q.gcnt[`T_LFP] == 16'h0000)
      else $error("integrating timer kept its count after operating");

   // Plain timer is zero one cycle after pickup loss
   chk_plain_clear: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE25]
      !pick[`T_OF] |=> s_q.tcnt[`T_OF] == 16'h0000)
      else $error("over frequency timer kept counting without pickup");

   // No selected inputs anywhere means no relay for two cycles on
   chk_empty_lines: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE24]
      (s_q.isel == '0) [*2] |=> relay_out == '0)
      else $error("relay driven by an empty logic line");

   // Relays only come from connected lines
   chk_relay_needs_osel: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE18]
      (s_q.osel == '0) |=> relay_out == '0)
      else $error("relay driven with no output connection");

endmodule

// ===== verif/prot_field.sv
// Purpose: Far-side model giving element pickups, line differences and logic inputs
// Assumes: The bench states wanted levels just after a rising edge
// Notes: Levels reach the block one edge later, as a filtered input would
module prot_field
   import prot_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Wanted conditions from the bench
   input wire elem_in_s want_elem,
   input wire logic [15:0] want_vab,
   input wire logic [15:0] want_vbc,
   input wire logic [7:0] want_lin,
   input wire logic want_inh,
   // Levels seen by the block
   output elem_in_s elem,
   output logic [15:0] vab_diff,
   output logic [15:0] vbc_diff,
   output logic [7:0] logic_in,
   output logic uf_uv_inhibit
);
   timeunit 1ns;
   timeprecision 1ps;

   // One register stage, so no input ever moves on the block's sampling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Dead measuring side while the relay restarts
         elem <= '0;
         vab_diff <= 16'h0000;
         vbc_diff <= 16'h0000;
         logic_in <= 8'h00;
         uf_uv_inhibit <= 1'b0;
      end else begin
         elem <= want_elem;
         vab_diff <= want_vab;
         vbc_diff <= want_vbc;
         logic_in <= want_lin;
         uf_uv_inhibit <= want_inh;
      end
   end
endmodule

// ===== verif/prot_matrix_test.sv
// Purpose: Self-checking bench of the protection timing and trip matrix
// Assumes: MS_CYCLES of 4, so one millisecond tick is four clocks
// Notes: Tick-based checks leave one tick of slack for tick phase
`include "prot_consts.svh"
module prot_matrix_test
   import prot_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Bus, field and relay signals
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, uf_uv_inhibit, want_inh = 1'b0;
   logic [`N_RELAY-1:0] relay_out;
   elem_in_s want_elem = '0, elem;
   logic [15:0] want_vab = 16'h0000, want_vbc = 16'h0000, vab_diff, vbc_diff;
   logic [7:0] want_lin = 8'h00, logic_in, lin;
   logic [32:0] exp_q[$]; // Expected {pslverr, prdata} of each read
   logic [29:0] rly_q[$]; // Mask and expected relays of each relay check
   int n_mismatch = 0, num_checks = 0, cyc = 0, seed = 32'h81d7;

   always #12.5 pclk = ~pclk;

   prot_matrix #(.MS_CYCLES(4)) prot_matrix_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .elem(elem), .vab_diff(vab_diff), .vbc_diff(vbc_diff),
      .logic_in(logic_in), .uf_uv_inhibit(uf_uv_inhibit), .relay_out(relay_out));
   prot_field prot_field_inst (.pclk(pclk), .presetn(presetn), .want_elem(want_elem),
      .want_vab(want_vab), .want_vbc(want_vbc), .want_lin(want_lin), .want_inh(want_inh),
      .elem(elem), .vab_diff(vab_diff), .vbc_diff(vbc_diff), .logic_in(logic_in),
      .uf_uv_inhibit(uf_uv_inhibit));

   // Closing report, reached from the main sequence or the watchdog
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Comparison of relay drives under a mask
   task automatic chk_relay(input logic [14:0] got, input logic [14:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Comparison of a read answer, {pslverr, prdata}
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; an idle cycle follows so no signal is driven twice per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      // Look at pready between edges, complete on the edge; the watchdog ends a hang
      do begin
         @(negedge pclk);
      end while (pready !== 1'b1);
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // The note goes on the queue before the bus cycle that answers it
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Note a relay expectation; the watcher compares it between edges
   task automatic rly(input logic [14:0] m, input logic [14:0] e);
      rly_q.push_back({m, e});
      @(negedge pclk);
      @(posedge pclk);
   endtask

   task automatic ticks(input int n);
      repeat (n * 4) @(posedge pclk);
   endtask

   // Read completions pop the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            chk({pslverr, prdata}, 33'h1_FFFF_FFFF);
         end else begin
            chk({pslverr, prdata}, exp_q.pop_front());
         end
      end
   end

   // Relay notes are taken off at the falling edge after they are made
   always @(negedge pclk) begin
      logic [29:0] note;
      if (rly_q.size() > 0) begin
         note = rly_q.pop_front();
         chk_relay(relay_out & note[29:15], note[14:0]);
      end
   end

   // Watchdog well above the few thousand cycles the sequence needs
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, an unmapped hole and the hold ceiling
      rd(`OFS_CTRL, 33'h0);
      rd(`OFS_RELAY, 33'h0);
      rd(12'h01C, 33'h1_0000_0000);
      wr(`OFS_HOLD, 32'h0000_003D);
      rd(`OFS_HOLD, 33'h0_0000_003C);
      wr(`OFS_HOLD, 32'h0000_0001);
      for (int i = 0; i < `N_TSET; i++) wr(`OFS_TSET + 12'(4 * i), 32'h0000_0005);
      // Lines 0..12 pass one function to the relay of the same number
      for (int l = 0; l < 13; l++) begin
         wr(`OFS_ISEL + 12'(4 * l), 32'h1 << l);
         wr(`OFS_OSEL + 12'(4 * l), 32'h1 << l);
      end
      wr(`OFS_ISEL + 12'h034, 32'h0018_0000);
      wr(`OFS_OSEL + 12'h034, 32'h0000_2000);
      wr(`OFS_ISEL + 12'h038, 32'h0800_0000);
      wr(`OFS_OSEL + 12'h038, 32'h0000_4000);
      wr(`OFS_ISEL + 12'h03C, 32'hC000_0000);
      wr(`OFS_OSEL + 12'h03C, 32'h0000_4000);
      wr(`OFS_OSEL + 12'h07C, 32'hFFFF_FFFF);
      rd(`OFS_OSEL + 12'h07C, 33'h0_0000_7FFF);
      wr(`OFS_CTRL, 32'h0000_0009);
      ticks(2);
      rly(15'h7FFF, 15'h4000);
      // Two phases are not enough, three start the timer
      want_elem.uv_ph <= 3'b011;
      ticks(8);
      rly(15'h0001, 15'h0000);
      want_elem.uv_ph <= 3'b111;
      ticks(3);
      rly(15'h0001, 15'h0000);
      ticks(5);
      rly(15'h0001, 15'h0001);
      want_elem.uv_ph <= 3'b000;
      repeat (3) @(posedge pclk);
      rly(15'h0001, 15'h0000);
      // Inhibit holds under voltage and under frequency, not over frequency
      want_inh <= 1'b1;
      want_elem.uv_ph <= 3'b111;
      want_elem.uf1 <= 1'b1;
      want_elem.uf2 <= 1'b1;
      want_elem.of <= 1'b1;
      ticks(8);
      rly(15'h001D, 15'h0010);
      want_inh <= 1'b0;
      ticks(8);
      rly(15'h001D, 15'h001D);
      // Either over voltage stage reaches the one output
      want_elem <= '{ovlo_ph: 3'b111, default: '0};
      ticks(8);
      rly(15'h0002, 15'h0002);
      want_elem.ovlo_ph <= 3'b000;
      want_elem.ovhi_ph <= 3'b111;
      ticks(2);
      rly(15'h0002, 15'h0000);
      ticks(6);
      rly(15'h0002, 15'h0002);
      want_elem.ovhi_ph <= 3'b000;
      // Balance: one evaluation is not enough; sign picks the failed side
      wr(`OFS_VS, 32'h0000_0064);
      want_vab <= 16'h00C8;
      ticks(10);
      rly(15'h0060, 15'h0000);
      ticks(60);
      rly(15'h0060, 15'h0040);
      want_vab <= 16'h0000;
      want_vbc <= 16'hFF38;
      ticks(70);
      rly(15'h0060, 15'h0020);
      rd(`OFS_LIVE, 33'h0_7800_0020);
      want_vbc <= 16'h0000;
      ticks(70);
      rly(15'h0060, 15'h0000);
      // Interrupted pickups: hold for one, plain for the other
      for (int k = 0; k < 3; k++) begin
         want_elem.oc <= (k != 1);
         want_elem.sef <= (k != 1);
         ticks(k == 1 ? 2 : 4);
      end
      rly(15'h0180, 15'h0080);
      want_elem.oc <= 1'b0;
      want_elem.sef <= 1'b0;
      ticks(1005);
      want_elem.oc <= 1'b1;
      ticks(3);
      rly(15'h0080, 15'h0000);
      want_elem.oc <= 1'b0;
      // Integrating timer rides a short gap, plain one does not
      for (int k = 0; k < 3; k++) begin
         want_elem.lfp <= (k != 1);
         want_elem.rp <= (k != 1);
         ticks(k == 1 ? 2 : 4);
      end
      rly(15'h0C00, 15'h0400);
      want_elem.lfp <= 1'b0;
      want_elem.rp <= 1'b0;
      repeat (3) @(posedge pclk);
      rly(15'h0400, 15'h0000);
      // A fresh pickup inside the drop-off time must start from zero again
      want_elem.lfp <= 1'b1;
      ticks(2);
      rly(15'h0400, 15'h0000);
      want_elem.lfp <= 1'b0;
      // Trial vector answers without touching live relays
      wr(`OFS_TEST_IN, 32'h0000_0001);
      wr(`OFS_CTRL, 32'h0000_0109);
      rd(`OFS_TEST_RESP, 33'h0_0000_0001);
      rly(15'h3FFF, 15'h0000);
      wr(`OFS_CTRL, 32'h0000_0009);
      // Random logic inputs through AND lines and OR relays
      repeat (8) begin
         lin = 8'($random(seed));
         want_lin <= lin;
         repeat (3) @(posedge pclk);
         rly(15'h6000, {~lin[0] | ~lin[3], lin[0] & lin[1], 13'h0000});
         rd(`OFS_LIVE, {1'b0, 1'b1, ~lin[3:0], lin, 19'h00000});
      end
      stop_test();
   end
endmodule
